// ---- design/sst_pkg.sv ----
// Shared constants and types for the busy/data-request timeout supervision link
package sst_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int T_BSY_NS = 400;
  localparam int T_READY_S = 31;
  localparam int T_CMD_S = 30;
  // Only the 400 ns busy limit divides, rounding down to whole cycles
  localparam int BSY_CYC = T_BSY_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int READY_CYC = T_READY_S * CLK_HZ;
  localparam int CMD_CYC = T_CMD_S * CLK_HZ;
  localparam int CNT_W = 30;
  localparam int BCNT_W = 4;
  localparam int COMRESET_CYC = 4;
  // Status byte field positions
  localparam int STS_ERR = 0;
  localparam int STS_DRQ = 3;
  localparam int STS_RDY = 6;
  localparam int STS_BSY = 7;
  localparam logic [7:0] STS_RESET = 8'h80;
  // Host timeout flag positions
  localparam int TO_BSY = 0;
  localparam int TO_READY = 1;
  localparam int TO_CMD = 2;
  localparam int TO_W = 3;
  typedef enum logic [1:0] {
    CLS_NODATA = 2'h0,
    CLS_PIO_IN = 2'h1,
    CLS_PIO_OUT = 2'h2,
    CLS_DMA = 2'h3
  } sst_class_t;
endpackage : sst_pkg

// ---- design/sst_link_if.sv ----
// Abstract FIS event and status link between host and drive
`timescale 1ns/1ns
interface sst_link_if;
  logic cmd_fis;
  sst_pkg::sst_class_t cmd_class;
  logic srst_fis;
  logic srst_bit;
  logic data_fis;
  logic comreset;
  logic reg_fis;
  logic pio_fis;
  logic [7:0] status;
  modport host (
    output cmd_fis, cmd_class, srst_fis, srst_bit, data_fis, comreset,
    input reg_fis, pio_fis, status
  );
  modport dev (
    input cmd_fis, cmd_class, srst_fis, srst_bit, data_fis, comreset,
    output reg_fis, pio_fis, status
  );
endinterface : sst_link_if

// ---- design/sst_dev.sv ----
// Drive end: answers resets and commands within their time limits
`timescale 1ns/1ns
module sst_dev #(
  parameter int READY_CYC = sst_pkg::READY_CYC,
  parameter int CMD_CYC = sst_pkg::CMD_CYC
) (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  sst_link_if.dev LINK,
  input wire logic READY_I,
  input wire logic DONE_I,
  input wire logic ERR_I,
  input wire logic XFER_I,
  output logic CMD_VALID_O,
  output sst_pkg::sst_class_t CMD_CLASS_O,
  output logic TIMEOUT_O
);
  localparam int W = sst_pkg::CNT_W;
  typedef enum logic [5:0] {
    D_BOOT = 6'h01,
    D_SRST = 6'h02,
    D_WAKE = 6'h04,
    D_IDLE = 6'h08,
    D_CMD = 6'h10,
    D_DATA = 6'h20
  } sst_dstate_t;
  sst_dstate_t state, next_state;
  logic [W-1:0] cnt, next_cnt;
  logic [7:0] status, next_status;
  logic reg_fis, next_reg_fis;
  logic pio_fis, next_pio_fis;
  logic cmd_valid, next_cmd_valid;
  logic timeout, next_timeout;
  sst_pkg::sst_class_t cls, next_cls;
  logic pio_cls;
  assign pio_cls = (cls == sst_pkg::CLS_PIO_IN) || (cls == sst_pkg::CLS_PIO_OUT);
  always_comb
  begin
    next_state = state;
    next_cnt = cnt + 1'b1;
    next_status = status;
    next_reg_fis = 1'b0;
    next_pio_fis = 1'b0;
    next_cmd_valid = 1'b0;
    next_timeout = 1'b0;
    next_cls = cls;
    unique case (state)
      D_BOOT, D_WAKE:
      begin
        // The forced answer flags a stuck spin-up; it reaches the host after the host's ready limit, unless COMRESET came in D_BOOT, which keeps cnt running
        if (!LINK.comreset && (READY_I || cnt == W'(READY_CYC - 1)))
        begin
          next_status = 8'h00;
          next_status[sst_pkg::STS_RDY] = 1'b1;
          next_status[sst_pkg::STS_ERR] = !READY_I;
          next_timeout = !READY_I;
          next_reg_fis = 1'b1;
          next_state = D_IDLE;
        end
      end
      D_SRST:
      begin
        if (LINK.srst_fis && !LINK.srst_bit)
        begin
          next_state = D_WAKE;
          next_cnt = '0;
        end
      end
      D_IDLE:
      begin
        if (LINK.cmd_fis)
        begin
          next_cls = LINK.cmd_class;
          next_cmd_valid = 1'b1;
          next_status[sst_pkg::STS_BSY] = 1'b1;
          next_state = D_CMD;
          next_cnt = '0;
        end
      end
      D_CMD:
      begin
        if (DONE_I || cnt == W'(CMD_CYC - 1))
        begin
          next_status = 8'h00;
          next_status[sst_pkg::STS_RDY] = 1'b1;
          next_status[sst_pkg::STS_ERR] = ERR_I || !DONE_I;
          next_timeout = !DONE_I;
          next_reg_fis = 1'b1;
          next_state = D_IDLE;
        end
        else if (pio_cls && XFER_I)
        begin
          next_status[sst_pkg::STS_BSY] = 1'b0;
          next_status[sst_pkg::STS_DRQ] = 1'b1;
          next_pio_fis = 1'b1;
          next_cnt = '0;
          if (cls == sst_pkg::CLS_PIO_OUT)
          begin
            next_state = D_DATA;
          end
        end
      end
      D_DATA:
      begin
        // No limit here: the host owns the data-out pacing
        if (LINK.data_fis)
        begin
          next_status[sst_pkg::STS_BSY] = 1'b1;
          next_status[sst_pkg::STS_DRQ] = 1'b0;
          next_state = D_CMD;
          next_cnt = '0;
        end
      end
    endcase
    if (LINK.srst_fis && LINK.srst_bit)
    begin
      next_state = D_SRST;
      next_status = sst_pkg::STS_RESET;
      next_reg_fis = 1'b0;
      next_pio_fis = 1'b0;
    end
    if (LINK.comreset)
    begin
      if (state != D_BOOT)
      begin
        next_cnt = '0;
      end
      next_state = D_BOOT;
      next_status = sst_pkg::STS_RESET;
      next_reg_fis = 1'b0;
      next_pio_fis = 1'b0;
      next_timeout = 1'b0;
    end
  end
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      state <= D_BOOT;
      cnt <= '0;
      status <= sst_pkg::STS_RESET;
      reg_fis <= 1'b0;
      pio_fis <= 1'b0;
      cmd_valid <= 1'b0;
      timeout <= 1'b0;
      cls <= sst_pkg::CLS_NODATA;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      status <= next_status;
      reg_fis <= next_reg_fis;
      pio_fis <= next_pio_fis;
      cmd_valid <= next_cmd_valid;
      timeout <= next_timeout;
      cls <= next_cls;
    end
  end
  assign LINK.reg_fis = reg_fis;
  assign LINK.pio_fis = pio_fis;
  assign LINK.status = status;
  assign CMD_VALID_O = cmd_valid;
  assign CMD_CLASS_O = cls;
  assign TIMEOUT_O = timeout;
endmodule : sst_dev

// ---- design/sst_host.sv ----
// Host end: issues resets and commands, keeps shadow busy and times the drive
//
// Contract
// - Drive ready with Register FIS within 31 s
// - Soft reset FIS, shadow busy within 400 ns
// - Reset on then off, ready in 31 s
// - After COMRESET drive ready within 31 s
// - Every command FIS, shadow busy within 400 ns
// - Non-data command completes within 30 s
// - PIO setup within 30 s of busy
// - PIO-in setup received, busy within 400 ns
// - PIO-out data FIS sent, busy within 400 ns
// - On timeout, soft reset then reissue command
`timescale 1ns/1ns
module sst_host #(
  parameter int READY_CYC = sst_pkg::READY_CYC,
  parameter int CMD_CYC = sst_pkg::CMD_CYC
) (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  sst_link_if.host LINK,
  input wire logic CMD_REQ_I,
  input sst_pkg::sst_class_t CMD_CLASS_I,
  input wire logic SRST_REQ_I,
  input wire logic COMRESET_REQ_I,
  input wire logic DATA_REQ_I,
  input wire logic AUTO_RETRY_I,
  input wire logic TO_CLR_I,
  output logic READY_O,
  output logic BUSY_O,
  output logic DRQ_O,
  output logic DONE_O,
  output logic XFER_O,
  output logic [sst_pkg::TO_W-1:0] TIMEOUT_O
);
  localparam int W = sst_pkg::CNT_W;
  localparam int BW = sst_pkg::BCNT_W;
  typedef enum logic [8:0] {
    H_RESET = 9'h001,
    H_WREADY = 9'h002,
    H_SRST1 = 9'h004,
    H_SRST0 = 9'h008,
    H_WSRST = 9'h010,
    H_IDLE = 9'h020,
    H_CMD = 9'h040,
    H_DIN = 9'h080,
    H_DOUT = 9'h100
  } sst_hstate_t;
  sst_hstate_t state, next_state;
  logic [W-1:0] cnt, next_cnt;
  sst_pkg::sst_class_t cls, next_cls;
  logic retry, next_retry;
  logic busy, next_busy;
  logic drq, next_drq;
  logic done, next_done;
  logic xfer, next_xfer;
  logic ready, next_ready;
  logic cmd_fis, next_cmd_fis;
  logic srst_fis, next_srst_fis;
  logic srst_bit, next_srst_bit;
  logic data_fis, next_data_fis;
  logic comreset, next_comreset;
  logic [sst_pkg::TO_W-1:0] to_set;
  logic [sst_pkg::TO_W-1:0] to_flags, next_to_flags;
  logic bwait, next_bwait;
  logic [BW-1:0] bcnt, next_bcnt;
  logic bstart;
  logic dev_ok;
  assign dev_ok = LINK.reg_fis && !LINK.status[sst_pkg::STS_BSY] &&
                  LINK.status[sst_pkg::STS_RDY];
  // Start events of the 400 ns window, seen on what was actually sent
  assign bstart = cmd_fis || data_fis || (srst_fis && srst_bit) ||
                  (LINK.pio_fis && cls == sst_pkg::CLS_PIO_IN);
  always_comb
  begin
    next_state = state;
    next_cnt = cnt + 1'b1;
    next_cls = cls;
    next_retry = retry;
    next_busy = busy;
    next_drq = drq;
    {next_done, next_xfer, next_cmd_fis, next_srst_fis, next_data_fis, next_comreset} = 6'h00;
    next_srst_bit = srst_bit;
    to_set = '0;
    unique case (state)
      H_RESET:
      begin
        next_comreset = 1'b1;
        next_busy = 1'b1;
        if (cnt == W'(sst_pkg::COMRESET_CYC - 1))
        begin
          next_comreset = 1'b0;
          next_state = H_WREADY;
        end
      end
      H_WREADY, H_WSRST:
      begin
        if (dev_ok)
        begin
          next_busy = 1'b0;
          next_state = H_IDLE;
        end
        else if (cnt == W'(READY_CYC - 1))
        begin
          to_set[sst_pkg::TO_READY] = 1'b1;
          next_busy = 1'b0;
          next_retry = 1'b0;
          next_state = H_IDLE;
        end
      end
      H_SRST1:
      begin
        next_srst_fis = 1'b1;
        next_srst_bit = 1'b1;
        next_busy = 1'b1;
        next_drq = 1'b0;
        next_state = H_SRST0;
      end
      H_SRST0:
      begin
        next_srst_fis = 1'b1;
        next_srst_bit = 1'b0;
        next_state = H_WSRST;
        next_cnt = '0;
      end
      H_IDLE:
      begin
        if (SRST_REQ_I)
        begin
          next_state = H_SRST1;
        end
        else if (CMD_REQ_I || retry)
        begin
          // A pending retry reissues the saved class and beats a new request
          next_cls = retry ? cls : CMD_CLASS_I;
          next_retry = 1'b0;
          next_cmd_fis = 1'b1;
          next_busy = 1'b1;
          next_state = H_CMD;
          next_cnt = '0;
        end
      end
      H_CMD:
      begin
        if (LINK.reg_fis)
        begin
          next_busy = LINK.status[sst_pkg::STS_BSY];
          next_drq = 1'b0;
          next_done = 1'b1;
          next_state = H_IDLE;
        end
        else if (LINK.pio_fis &&
                 (cls == sst_pkg::CLS_PIO_IN || cls == sst_pkg::CLS_PIO_OUT))
        begin
          next_busy = 1'b0;
          next_drq = 1'b1;
          next_xfer = 1'b1;
          next_state = (cls == sst_pkg::CLS_PIO_IN) ? H_DIN : H_DOUT;
        end
        else if (cnt == W'(CMD_CYC - 1))
        begin
          to_set[sst_pkg::TO_CMD] = 1'b1;
          next_busy = 1'b0;
          next_drq = 1'b0;
          if (AUTO_RETRY_I)
          begin
            next_retry = 1'b1;
            next_state = H_SRST1;
          end
          else
          begin
            next_state = H_IDLE;
          end
        end
      end
      H_DIN:
      begin
        // The data-in block is taken in one beat by this model
        next_busy = 1'b1;
        next_drq = 1'b0;
        next_state = H_CMD;
        next_cnt = '0;
      end
      H_DOUT:
      begin
        if (DATA_REQ_I)
        begin
          next_data_fis = 1'b1;
          next_busy = 1'b1;
          next_drq = 1'b0;
          next_state = H_CMD;
          next_cnt = '0;
        end
      end
    endcase
    if (COMRESET_REQ_I)
    begin
      next_state = H_RESET;
      next_cnt = '0;
      next_retry = 1'b0;
      next_busy = 1'b1;
      next_drq = 1'b0;
      // Raised on the request edge so the line stands the full count
      {next_cmd_fis, next_srst_fis, next_data_fis, next_comreset} = 4'h1;
    end
    next_ready = (next_state == H_IDLE);
  end
  always_comb
  begin
    next_bwait = bwait;
    next_bcnt = bcnt;
    next_to_flags = to_flags & ~{sst_pkg::TO_W{TO_CLR_I}};
    if (bstart)
    begin
      next_bwait = 1'b1;
      next_bcnt = '0;
    end
    else if (bwait && busy)
    begin
      next_bwait = 1'b0;
    end
    else if (bwait)
    begin
      next_bcnt = bcnt + 1'b1;
      if (bcnt == BW'(sst_pkg::BSY_CYC - 1))
      begin
        next_bwait = 1'b0;
        next_to_flags[sst_pkg::TO_BSY] = 1'b1;
      end
    end
    // Set wins over a clear in the same cycle
    next_to_flags = next_to_flags | to_set;
  end
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      state <= H_WREADY;
      cnt <= '0;
      cls <= sst_pkg::CLS_NODATA;
      busy <= 1'b1;
      {retry, drq, done, xfer, ready, cmd_fis, srst_fis, srst_bit} <= 8'h00;
      {data_fis, comreset, bwait} <= 3'h0;
      to_flags <= '0;
      bcnt <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      cls <= next_cls;
      {retry, busy, drq, srst_bit, bwait, done, xfer} <=
        {next_retry, next_busy, next_drq, next_srst_bit, next_bwait, next_done, next_xfer};
      {ready, cmd_fis, srst_fis, data_fis, comreset} <=
        {next_ready, next_cmd_fis, next_srst_fis, next_data_fis, next_comreset};
      to_flags <= next_to_flags;
      bcnt <= next_bcnt;
    end
  end
  assign LINK.cmd_fis = cmd_fis;
  assign LINK.cmd_class = cls;
  assign LINK.srst_fis = srst_fis;
  assign LINK.srst_bit = srst_bit;
  assign LINK.data_fis = data_fis;
  assign LINK.comreset = comreset;
  assign READY_O = ready;
  assign BUSY_O = busy;
  assign DRQ_O = drq;
  assign DONE_O = done;
  assign XFER_O = xfer;
  assign TIMEOUT_O = to_flags;
endmodule : sst_host

// ---- test/sst_link_chk.sv ----
// Link-side assertions on busy, ready and frame timing between host and drive
`timescale 1ns/1ns
module sst_link_chk #(
  parameter int READY_CYC = 50,
  parameter int CMD_CYC = 40
) (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic cmd_fis,
  input sst_pkg::sst_class_t cmd_class,
  input wire logic srst_fis,
  input wire logic srst_bit,
  input wire logic data_fis,
  input wire logic comreset,
  input wire logic reg_fis,
  input wire logic pio_fis,
  input wire logic [7:0] status
);
  // Small defaults: full-size limits cannot be unrolled as delay ranges
  localparam int RDY_LIM = READY_CYC + 2;
  localparam int CMD_LIM = CMD_CYC + 2;
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  sequence dev_idle;
    status[sst_pkg::STS_RDY] && !status[sst_pkg::STS_BSY];
  endsequence
  sequence dev_answer;
    reg_fis || pio_fis || comreset || srst_fis;
  endsequence
  // Class of the command in flight, for the setup-frame check
  sst_pkg::sst_class_t last_cls;
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      last_cls <= sst_pkg::CLS_NODATA;
    end
    else if (cmd_fis)
    begin
      last_cls <= cmd_class;
    end
  end
  pwr_ready_a: assert property ($fell(SYS_RST_I) |-> ##[0:RDY_LIM] reg_fis)
    else $error("no register frame after power-on");
  srst_pair_a: assert property (srst_fis && srst_bit |=> srst_fis && !srst_bit)
    else $error("soft reset frames not paired");
  srst_ready_a: assert property (srst_fis && !srst_bit |-> ##[1:RDY_LIM] reg_fis)
    else $error("no answer after soft reset");
  comreset_hold_a: assert property ($rose(comreset) |-> comreset[*4] ##1 !comreset)
    else $error("comreset width wrong");
  comreset_ready_a: assert property ($fell(comreset) |-> ##[0:RDY_LIM] reg_fis)
    else $error("no answer after comreset");
  reg_status_a: assert property (reg_fis && !status[sst_pkg::STS_ERR] |-> dev_idle)
    else $error("register frame without ready status");
  cmd_busy_a: assert property (cmd_fis ##0 dev_idle |=> status[sst_pkg::STS_BSY])
    else $error("drive not busy after command");
  cmd_answer_a: assert property (cmd_fis ##0 dev_idle |-> ##[1:CMD_LIM] dev_answer)
    else $error("command not answered in time");
  pio_status_a: assert property (pio_fis |-> status[sst_pkg::STS_DRQ]
    && !status[sst_pkg::STS_BSY])
    else $error("setup frame without data request");
  pio_class_a: assert property (pio_fis |-> last_cls == sst_pkg::CLS_PIO_IN
    || last_cls == sst_pkg::CLS_PIO_OUT)
    else $error("setup frame for a class without data phase");
  data_busy_a: assert property (data_fis |=> status[sst_pkg::STS_BSY]
    && !status[sst_pkg::STS_DRQ])
    else $error("drive not busy after data frame");
endmodule : sst_link_chk

// ---- test/test_sata_status_timeout_monitor.sv ----
// Bench: host and drive joined over the link, command classes checked by a queue model
`timescale 1ns/1ns
module test_sata_status_timeout_monitor;
  localparam int RDY = 50;
  localparam int CMD = 40;
  logic clk;
  logic rst;
  logic ready, done, err, xfer, cmd_req, srst_req, com_req, data_req, retry, to_clr;
  sst_pkg::sst_class_t cls;
  sst_pkg::sst_class_t dev_cls;
  logic cmd_valid, dev_to, h_ready, h_busy, h_drq, h_done, h_xfer;
  logic [sst_pkg::TO_W-1:0] h_to;
  int n_mismatch = 0;
  int tests_run = 0;
  int off;
  sst_pkg::sst_class_t cls_q[$];
  sst_link_if link();
  sst_host #(.READY_CYC(RDY), .CMD_CYC(CMD)) sst_host_i (.SYS_CLK_I(clk), .SYS_RST_I(rst),
    .LINK(link), .CMD_REQ_I(cmd_req), .CMD_CLASS_I(cls), .SRST_REQ_I(srst_req),
    .COMRESET_REQ_I(com_req), .DATA_REQ_I(data_req), .AUTO_RETRY_I(retry), .TO_CLR_I(to_clr),
    .READY_O(h_ready), .BUSY_O(h_busy), .DRQ_O(h_drq), .DONE_O(h_done), .XFER_O(h_xfer),
    .TIMEOUT_O(h_to));
  sst_dev #(.READY_CYC(RDY), .CMD_CYC(CMD)) sst_dev_i (.SYS_CLK_I(clk), .SYS_RST_I(rst),
    .LINK(link), .READY_I(ready), .DONE_I(done), .ERR_I(err), .XFER_I(xfer),
    .CMD_VALID_O(cmd_valid), .CMD_CLASS_O(dev_cls), .TIMEOUT_O(dev_to));
  sst_link_chk #(.READY_CYC(RDY), .CMD_CYC(CMD)) sst_link_chk_i (.SYS_CLK_I(clk),
    .SYS_RST_I(rst), .cmd_fis(link.cmd_fis), .cmd_class(link.cmd_class),
    .srst_fis(link.srst_fis), .srst_bit(link.srst_bit), .data_fis(link.data_fis),
    .comreset(link.comreset), .reg_fis(link.reg_fis), .pio_fis(link.pio_fis),
    .status(link.status));
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  function automatic logic sig(input int k);
    case (k)
      0: sig = h_ready;
      1: sig = h_xfer;
      2: sig = h_done;
      3: sig = h_busy;
      4: sig = dev_to;
      8: sig = cmd_valid;
      default: sig = h_to[k - 5];
    endcase
  endfunction : sig
  // Bounded poll; a miss is reported as a mismatch rather than hanging
  task automatic wait_ev(input string what, input int k, input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (sig(k) !== 1'b1 && n < lim);
    chk(what, 1, sig(k));
  endtask : wait_ev
  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: cmd_req <= 1'b1;
      1: srst_req <= 1'b1;
      2: com_req <= 1'b1;
      3: data_req <= 1'b1;
      4: xfer <= 1'b1;
      5: done <= 1'b1;
      default: to_clr <= 1'b1;
    endcase
    @(posedge clk);
    {cmd_req, srst_req, com_req, data_req, xfer, done, to_clr} <= 7'h00;
  endtask : pulse
  task automatic issue(input sst_pkg::sst_class_t c, input logic rt);
    @(posedge clk);
    cls <= c;
    retry <= rt;
    err <= 1'($urandom_range(1));
    cls_q.push_back(c);
    pulse(0);
    wait_ev("busy after command", 3, sst_pkg::BSY_CYC);
  endtask : issue
  task automatic finish_cmd();
    pulse(5);
    wait_ev("done", 2, 6);
    chk("ready at done", 1, h_ready);
  endtask : finish_cmd
  task automatic run_cmd(input sst_pkg::sst_class_t c);
    issue(c, 1'b0);
    pulse(4);
    if (c == sst_pkg::CLS_PIO_IN || c == sst_pkg::CLS_PIO_OUT)
    begin
      wait_ev("pio setup", 1, 6);
      chk("drq on setup", 1, h_drq);
      if (c == sst_pkg::CLS_PIO_IN)
      begin
        @(posedge clk);
        #1;
        chk("busy after data-in", 1, h_busy);
      end
      else
      begin
        pulse(3);
        wait_ev("busy after data-out", 3, sst_pkg::BSY_CYC);
      end
    end
    else
    begin
      @(posedge clk);
      #1;
      chk("setup refused", 0, h_xfer);
    end
    finish_cmd();
  endtask : run_cmd
  task automatic cmd_timeout(input logic rt);
    issue(sst_pkg::CLS_DMA, rt);
    wait_ev("drive timeout", 4, CMD + 4);
    chk("host command flag", 1, h_to[sst_pkg::TO_CMD]);
    if (rt)
    begin
      cls_q.push_back(sst_pkg::CLS_DMA);
      wait_ev("reissue", 8, RDY + 20);
      finish_cmd();
    end
    else
      wait_ev("ready after timeout", 0, 10);
    pulse(6);
    @(posedge clk);
    #1;
    chk("flags cleared", 0, h_to);
  endtask : cmd_timeout
  // Class model: each accepted command pops the class the bench issued
  always @(posedge clk)
  begin
    #1;
    if (cmd_valid === 1'b1)
    begin
      if (cls_q.size() == 0)
        chk("unexpected command", 0, 1);
      else
        chk("command class", 32'(cls_q.pop_front()), 32'(dev_cls));
    end
  end
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  initial
  begin
    rst = 1'b1;
    ready = 1'b1;
    {err, retry} = 2'h0;
    cls = sst_pkg::CLS_NODATA;
    {cmd_req, srst_req, com_req, data_req, xfer, done, to_clr} = 7'h00;
    void'($urandom(51922));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wait_ev("power-on ready", 0, RDY + 10);
    chk("idle busy", 0, h_busy);
    off = $urandom_range(3);
    for (int i = 0; i < 4; i++)
      run_cmd(sst_pkg::sst_class_t'(2'((i + off) % 4)));
    pulse(1);
    wait_ev("busy after soft reset", 3, sst_pkg::BSY_CYC);
    wait_ev("ready after soft reset", 0, RDY + 10);
    cmd_timeout(1'b0);
    cmd_timeout(1'b1);
    @(posedge clk);
    ready <= 1'b0;
    pulse(2);
    repeat (8) @(posedge clk);
    ready <= 1'b1;
    wait_ev("ready after comreset", 0, RDY + 10);
    @(posedge clk);
    ready <= 1'b0;
    pulse(2);
    wait_ev("drive ready timeout", 4, RDY + 10);
    chk("host ready flag", 1, h_to[sst_pkg::TO_READY]);
    chk("busy flag", 0, h_to[sst_pkg::TO_BSY]);
    conclude();
  end
endmodule : test_sata_status_timeout_monitor
